// file: verilog/ddr_strobe_capture_io.sv
// DDR read strobe capture and write output datapath
//
// Functional notes
// - Delay strobe per code, clock capture stage.
// - Strobe shift is ninety degrees.
// - Undelayed strobe copy goes to core.
// - Preamble detect derived from strobe.
// - Clock low at detect gives polarity 0.
// - Clock high at detect gives polarity 1.
// - Capture data on both delayed strobe edges.
// - Stream A retimed to falling edge.
// - System clock syncs streams B and C.
// - Sync gate defaults on, plus set/reset.
// - DDR output pin shows rising then falling half.
// - One output structure serves all outputs.
// - DDR outputs: no enable, tristate set only.
// - SDR output mode has enable and set/reset.
// - Reset clears flops, not output latches.
// - Delay code updates while update input low.
`timescale 1ns/10ps
module ddr_strobe_capture_io
  import ddr_io_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    strobe_in,
  input  wire logic [DATA_W-1:0]       dq_in,
  input  wire logic                    read_pulse_in,
  input  wire logic                    delay_update_n_in,
  input  wire logic [DELAY_CODE_W-1:0] delay_code_in,
  input  wire logic                    sync_gate_in,
  input  wire logic                    capture_set_reset_in,
  input  wire logic                    capture_polarity_in,
  input  wire logic [DATA_W-1:0]       write_rise_data_in,
  input  wire logic [DATA_W-1:0]       write_fall_data_in,
  input  wire logic                    strobe_rise_data_in,
  input  wire logic                    strobe_fall_data_in,
  input  wire logic                    dq_tristate_rise_in,
  input  wire logic                    dq_tristate_fall_in,
  input  wire logic                    strobe_tristate_in,
  input  wire logic                    output_set_reset_in,
  output logic      [DELAY_CODE_W-1:0] delay_code_out,
  output logic                         delayed_strobe_out,
  output logic                         raw_strobe_copy_out,
  output logic                         preamble_detect_out,
  output logic                         capture_clock_polarity_out,
  output logic      [DATA_W-1:0]       rising_capture_out,
  output logic      [DATA_W-1:0]       falling_capture_out,
  output logic      [DATA_W-1:0]       dq_out,
  output logic      [DATA_W-1:0]       dq_oe_n_out,
  output logic                         strobe_out,
  output logic                         strobe_oe_n_out,
  output logic                         mem_clock_p_out,
  output logic                         mem_clock_n_out
);
  // Strobe-domain capture registers
  logic [DATA_W-1:0]       stream_a;
  logic [DATA_W-1:0]       stream_b;
  logic [DATA_W-1:0]       stream_c;
  // Held calibrator code
  logic [DELAY_CODE_W-1:0] delay_code;
  // Strobe synchronisers on both system clock edges
  logic                    strobe_pos_meta;
  logic                    strobe_pos_sync;
  logic                    strobe_neg_meta;
  logic                    strobe_neg_sync;
  logic                    strobe_pos_prev;
  // Preamble detector
  preamble_state_t         state;
  preamble_state_t         next_state;
  logic                    read_prev;
  logic                    capture_clock_polarity;
  logic                    next_polarity;
  logic                    rise_seen;
  // System clock sync stage, both polarities
  logic [DATA_W-1:0]       sync_pos_b;
  logic [DATA_W-1:0]       sync_pos_c;
  logic [DATA_W-1:0]       sync_neg_b;
  logic [DATA_W-1:0]       sync_neg_c;
  logic [DATA_W-1:0]       tri_pin;
  logic                    strobe_tri_pin;

  // Calibrator code is refreshed only while update is held low
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      delay_code <= '0;
    end else if (!delay_update_n_in) begin
      delay_code <= delay_code_in;
    end
  end

  // The code steers the pad quarter-cycle delay taps
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      delay_code_out <= '0;
    end else begin
      delay_code_out <= delay_code;
    end
  end

  // Stream A on rising edge of the delayed strobe
  always_ff @(posedge strobe_in or posedge rst_in) begin
    if (rst_in) begin
      stream_a <= '0;
    end else begin
      stream_a <= dq_in;
    end
  end

  // Stream B on falling edge, stream C retimes A to that edge
  always_ff @(negedge strobe_in or posedge rst_in) begin
    if (rst_in) begin
      stream_b <= '0;
      stream_c <= '0;
    end else begin
      stream_b <= dq_in;
      stream_c <= stream_a;
    end
  end

  // Two-flop synchroniser of the strobe on the rising system edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strobe_pos_meta <= 1'b0;
      strobe_pos_sync <= 1'b0;
      strobe_pos_prev <= 1'b0;
    end else begin
      strobe_pos_meta <= strobe_in;
      strobe_pos_sync <= strobe_pos_meta;
      strobe_pos_prev <= strobe_pos_sync;
    end
  end

  // Two-flop synchroniser on the falling edge reveals clock phase
  always_ff @(negedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strobe_neg_meta <= 1'b0;
      strobe_neg_sync <= 1'b0;
    end else begin
      strobe_neg_meta <= strobe_in;
      strobe_neg_sync <= strobe_neg_meta;
    end
  end

  // Undelayed strobe copy and delayed strobe view for the core
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      raw_strobe_copy_out <= 1'b0;
      delayed_strobe_out  <= 1'b0;
    end else begin
      raw_strobe_copy_out <= strobe_pos_sync;
      delayed_strobe_out  <= strobe_pos_prev;
    end
  end

  // Read pulse edge history
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      read_prev <= 1'b0;
    end else begin
      read_prev <= read_pulse_in;
    end
  end

  // A rise is seen once the falling-edge synchroniser reports strobe high or the rising-edge one sees it newly high
  assign rise_seen = strobe_neg_sync || (strobe_pos_sync && !strobe_pos_prev);

  // Preamble detector: arm on read rise, wait after read falls
  always_comb begin
    next_state    = state;
    next_polarity = capture_clock_polarity;
    case (state)
      PRE_IDLE: begin
        if (read_pulse_in && !read_prev) begin
          next_state = PRE_ARMED;
        end
      end
      PRE_ARMED: begin
        if (!read_pulse_in) begin
          next_state = PRE_WAIT;
        end
      end
      PRE_WAIT: begin
        if (rise_seen) begin
          next_state = PRE_DETECTED;
          // Falling-edge chain caught it first: clock was high
          if (strobe_neg_sync && !strobe_pos_sync) begin
            next_polarity = POL_INVERT;
          end else begin
            next_polarity = POL_NO_INVERT;
          end
        end
      end
      PRE_DETECTED: begin
        // Next read may overlap the tail of this burst
        if (read_pulse_in && !read_prev) begin
          next_state = PRE_ARMED;
        end else if (!strobe_pos_sync && !strobe_neg_sync && !read_pulse_in) begin
          next_state = PRE_DETECTED;
        end
      end
      default: begin
        next_state = PRE_IDLE;
      end
    endcase
  end

  // Detector state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= PRE_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Polarity held from one detected preamble to the next
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      capture_clock_polarity <= POL_RESET;
    end else begin
      capture_clock_polarity <= next_polarity;
    end
  end

  // Detector outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      preamble_detect_out        <= 1'b0;
      capture_clock_polarity_out <= POL_RESET;
    end else begin
      preamble_detect_out        <= (next_state == PRE_DETECTED);
      capture_clock_polarity_out <= next_polarity;
    end
  end

  // Sync registers on the true system clock
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_pos_b <= '0;
      sync_pos_c <= '0;
    end else if (capture_set_reset_in) begin
      sync_pos_b <= '0;
      sync_pos_c <= '0;
    end else if (sync_gate_in) begin
      sync_pos_b <= stream_b;
      sync_pos_c <= stream_c;
    end
  end

  // Sync registers on the inverted system clock
  always_ff @(negedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_neg_b <= '0;
      sync_neg_c <= '0;
    end else if (capture_set_reset_in) begin
      sync_neg_b <= '0;
      sync_neg_c <= '0;
    end else if (sync_gate_in) begin
      sync_neg_b <= stream_b;
      sync_neg_c <= stream_c;
    end
  end

  // Polarity picks the sync edge; result lands on rising clock edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rising_capture_out  <= '0;
      falling_capture_out <= '0;
    end else if (capture_polarity_in == POL_INVERT) begin
      rising_capture_out  <= sync_neg_c;
      falling_capture_out <= sync_neg_b;
    end else begin
      rising_capture_out  <= sync_pos_c;
      falling_capture_out <= sync_pos_b;
    end
  end

  // Write data DDR register
  ddr_output_register_block #(
    .WIDTH (DATA_W),
    .MODE  (OUT_MODE_DDR)
  ) u_dq_out (
    .clk_in                (clk_in),
    .rst_in                (rst_in),
    .rising_half_input_in  (write_rise_data_in),
    .falling_half_input_in (write_fall_data_in),
    .local_set_reset_in    (output_set_reset_in),
    .sdr_enable_in         (1'b1),
    .pin_out               (dq_out)
  );

  // Write data tristate DDR register; set means not driving
  ddr_output_register_block #(
    .WIDTH (DATA_W),
    .MODE  (OUT_MODE_TRISTATE)
  ) u_dq_tri (
    .clk_in                (clk_in),
    .rst_in                (rst_in),
    .rising_half_input_in  ({DATA_W{dq_tristate_rise_in}}),
    .falling_half_input_in ({DATA_W{dq_tristate_fall_in}}),
    .local_set_reset_in    (output_set_reset_in),
    .sdr_enable_in         (1'b1),
    .pin_out               (tri_pin)
  );
  assign dq_oe_n_out = tri_pin;

  // Strobe output DDR register
  ddr_output_register_block #(
    .WIDTH (1),
    .MODE  (OUT_MODE_DDR)
  ) u_strobe_out (
    .clk_in                (clk_in),
    .rst_in                (rst_in),
    .rising_half_input_in  (strobe_rise_data_in),
    .falling_half_input_in (strobe_fall_data_in),
    .local_set_reset_in    (output_set_reset_in),
    .sdr_enable_in         (1'b1),
    .pin_out               (strobe_out)
  );

  // Strobe tristate uses the single-rate mode
  ddr_output_register_block #(
    .WIDTH (1),
    .MODE  (OUT_MODE_SDR)
  ) u_strobe_tri (
    .clk_in                (clk_in),
    .rst_in                (rst_in),
    .rising_half_input_in  (strobe_tristate_in),
    .falling_half_input_in (strobe_tristate_in),
    .local_set_reset_in    (output_set_reset_in),
    .sdr_enable_in         (1'b1),
    .pin_out               (strobe_tri_pin)
  );
  assign strobe_oe_n_out = strobe_tri_pin;

  // Memory clock pair: constant halves, opposite in phase
  ddr_output_register_block #(
    .WIDTH (1),
    .MODE  (OUT_MODE_DDR)
  ) u_clk_p (
    .clk_in                (clk_in),
    .rst_in                (rst_in),
    .rising_half_input_in  (CLK_PAIR_P_RISE),
    .falling_half_input_in (CLK_PAIR_P_FALL),
    .local_set_reset_in    (1'b0),
    .sdr_enable_in         (1'b1),
    .pin_out               (mem_clock_p_out)
  );

  ddr_output_register_block #(
    .WIDTH (1),
    .MODE  (OUT_MODE_DDR)
  ) u_clk_n (
    .clk_in                (clk_in),
    .rst_in                (rst_in),
    .rising_half_input_in  (CLK_PAIR_P_FALL),
    .falling_half_input_in (CLK_PAIR_P_RISE),
    .local_set_reset_in    (1'b0),
    .sdr_enable_in         (1'b1),
    .pin_out               (mem_clock_n_out)
  );
endmodule

// file: include/ddr_io_pkg.sv
// Shared constants and types for the DDR strobe capture datapath
package ddr_io_pkg;
  localparam int          DATA_W_DEF      = 8;
  localparam int          DELAY_CODE_W    = 9;
  localparam int          STROBE_SHIFT_DEG = 90;
  localparam logic        POL_NO_INVERT   = 1'b0;
  localparam logic        POL_INVERT      = 1'b1;
  localparam logic        POL_RESET       = 1'b0;
  localparam logic        SYNC_GATE_DEF   = 1'b1;
  localparam logic        TRISTATE_SET    = 1'b1;
  localparam logic        CLK_PAIR_P_RISE = 1'b0;
  localparam logic        CLK_PAIR_P_FALL = 1'b1;
  localparam int          SYNC_STAGES     = 2;

  typedef enum logic [1:0] {
    PRE_IDLE     = 2'b00,
    PRE_ARMED    = 2'b01,
    PRE_WAIT     = 2'b11,
    PRE_DETECTED = 2'b10
  } preamble_state_t;

  typedef enum logic [1:0] {
    OUT_MODE_DDR      = 2'b00,
    OUT_MODE_TRISTATE = 2'b01,
    OUT_MODE_SDR      = 2'b11
  } out_mode_t;
endpackage

// file: verilog/ddr_output_register_block.sv
// Output DDR register for data, strobe, clock pair and tristate control
`timescale 1ns/10ps
module ddr_output_register_block
  import ddr_io_pkg::*;
#(
  parameter int        WIDTH = 1,
  parameter out_mode_t MODE  = OUT_MODE_DDR
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] rising_half_input_in,
  input  wire logic [WIDTH-1:0] falling_half_input_in,
  input  wire logic             local_set_reset_in,
  input  wire logic             sdr_enable_in,
  output logic      [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] rise_ff;
  logic [WIDTH-1:0] fall_ff;
  logic [WIDTH-1:0] fall_latch;
  logic             set_reset_active;

  // Set/reset acts only in tristate mode or plain SDR mode
  assign set_reset_active = local_set_reset_in && (MODE != OUT_MODE_DDR);

  // Rising-half flop; SDR mode alone honours the enable
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rise_ff <= '0;
    end else if (set_reset_active) begin
      rise_ff <= (MODE == OUT_MODE_TRISTATE) ? '1 : '0;
    end else if ((MODE != OUT_MODE_SDR) || sdr_enable_in) begin
      rise_ff <= rising_half_input_in;
    end
  end

  // Falling-half flop loads on rising edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fall_ff <= '0;
    end else if (set_reset_active) begin
      fall_ff <= (MODE == OUT_MODE_TRISTATE) ? '1 : '0;
    end else begin
      fall_ff <= falling_half_input_in;
    end
  end

  // Half-cycle retiming stage; reset leaves it untouched
  always_ff @(negedge clk_in) begin
    fall_latch <= fall_ff;
  end

  // SDR pin always shows the rising half; other modes show rising half while clock high, falling half while low
  assign pin_out = (MODE == OUT_MODE_SDR) ? rise_ff
                 : (clk_in ? rise_ff : fall_latch);
endmodule

// file: sim/ddr_strobe_capture_io_props.sv
// Port checks for the DDR strobe capture datapath
`timescale 1ns/10ps
module ddr_strobe_capture_io_props
  import ddr_io_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF
) (
  input wire logic                    clk_in,
  input wire logic                    rst_in,
  input wire logic                    read_pulse_in,
  input wire logic                    delay_update_n_in,
  input wire logic [DELAY_CODE_W-1:0] delay_code_in,
  input wire logic [DATA_W-1:0]       write_rise_data_in,
  input wire logic [DATA_W-1:0]       write_fall_data_in,
  input wire logic                    output_set_reset_in,
  input wire logic [DELAY_CODE_W-1:0] delay_code_out,
  input wire logic                    preamble_detect_out,
  input wire logic                    capture_clock_polarity_out,
  input wire logic [DATA_W-1:0]       dq_out,
  input wire logic [DATA_W-1:0]       dq_oe_n_out,
  input wire logic                    mem_clock_p_out,
  input wire logic                    mem_clock_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Two edges in a row with update idle, or with the read pulse up
  sequence update_idle;
    delay_update_n_in ##1 delay_update_n_in;
  endsequence
  sequence read_held;
    read_pulse_in ##1 read_pulse_in;
  endsequence

  chk_code_load: assert property (
    !delay_update_n_in |-> ##2 delay_code_out == $past(delay_code_in, 2))
    else $error("delay code not loaded");
  chk_code_hold: assert property (update_idle |=> $stable(delay_code_out))
    else $error("delay code moved without update");
  chk_polarity_held: assert property (
    !$rose(preamble_detect_out) |-> $stable(capture_clock_polarity_out))
    else $error("polarity changed outside detection");
  chk_detect_rearm: assert property (read_held |=> !preamble_detect_out)
    else $error("preamble detect not cleared by read");
  chk_rise_half: assert property (
    @(negedge clk_in) dq_out == write_rise_data_in)
    else $error("rising half not on pin");
  chk_fall_half: assert property (
    !$past(rst_in) |-> dq_out == $past(write_fall_data_in))
    else $error("falling half not on pin");
  chk_clock_pair: assert property (
    !$past(rst_in) |-> mem_clock_p_out == CLK_PAIR_P_FALL && mem_clock_n_out != mem_clock_p_out)
    else $error("memory clock pair wrong in low phase");
  chk_tristate_set: assert property (
    @(negedge clk_in) output_set_reset_in |-> dq_oe_n_out == {DATA_W{TRISTATE_SET}})
    else $error("set/reset did not release data pins");
endmodule

bind ddr_strobe_capture_io ddr_strobe_capture_io_props #(.DATA_W(DATA_W)) u_props (
  .clk_in                     (clk_in),
  .rst_in                     (rst_in),
  .read_pulse_in              (read_pulse_in),
  .delay_update_n_in          (delay_update_n_in),
  .delay_code_in              (delay_code_in),
  .write_rise_data_in         (write_rise_data_in),
  .write_fall_data_in         (write_fall_data_in),
  .output_set_reset_in        (output_set_reset_in),
  .delay_code_out             (delay_code_out),
  .preamble_detect_out        (preamble_detect_out),
  .capture_clock_polarity_out (capture_clock_polarity_out),
  .dq_out                     (dq_out),
  .dq_oe_n_out                (dq_oe_n_out),
  .mem_clock_p_out            (mem_clock_p_out),
  .mem_clock_n_out            (mem_clock_n_out)
);

// file: sim/ddr_mem_model.sv
// Memory device model driving read bursts on the strobe and data pins
`timescale 1ns/10ps
module ddr_mem_model #(
  parameter int W = 8
) (
  output logic         strobe_out,
  output logic [W-1:0] dq_out
);
  // Strobe parked low between bursts
  initial begin
    strobe_out = 1'h0;
    dq_out = '0;
  end

  // Preamble, then one beat per 30 ns; data leads each edge by a quarter
  // period, standing in for the pad delay taps that centre the strobe
  task automatic burst(input logic [2*W-1:0] beats[$]);
    #30;
    foreach (beats[i]) begin
      dq_out = beats[i][2*W-1:W];
      #7.5;
      strobe_out = 1'h1;
      #7.5;
      dq_out = beats[i][W-1:0];
      #7.5;
      strobe_out = 1'h0;
      #7.5;
    end
    dq_out = ~dq_out; // Released bus never shows the last value
  endtask
endmodule

// file: sim/ddr_strobe_capture_io_tb.sv
// Self-checking bench for the DDR strobe capture datapath
`timescale 1ns/10ps
module ddr_strobe_capture_io_tb
  import ddr_io_pkg::*;
;
  logic        clk_in = 1'h0;
  logic        rst_in = 1'h1;
  logic        read_pulse_in = 1'h0;
  logic        delay_update_n_in = 1'h1;
  logic [8:0]  delay_code_in = 9'h000;
  logic        capture_set_reset_in = 1'h0;
  logic        output_set_reset_in = 1'h0;
  logic [7:0]  write_rise_data_in = 8'h00;
  logic [7:0]  write_fall_data_in = 8'h00;
  logic [4:0]  misc = 5'h00; // Strobe halves, data tristate halves, strobe tristate
  logic        watch = 1'h0;
  logic        sync_gate = SYNC_GATE_DEF;
  logic        raw_prev = 1'h0;
  logic [15:0] prev;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'hFDACBC3E;
  int          miscompares = 0;
  int          tests_run = 0;
  wire         mem_strobe, preamble_detect_out, capture_clock_polarity_out;
  wire         strobe_out, strobe_oe_n_out;
  wire         dly_strobe, raw_copy, clk_p, clk_n;
  wire [7:0]   mem_dq, rising_capture_out, falling_capture_out, dq_out, dq_oe_n_out;
  wire [8:0]   delay_code_out;
  wire [15:0]  cap = {rising_capture_out, falling_capture_out};

  // Design with its polarity output fed back to the capture blocks
  ddr_strobe_capture_io #(.DATA_W(8)) u_dut (
    .clk_in, .rst_in, .strobe_in(mem_strobe), .dq_in(mem_dq), .read_pulse_in,
    .delay_update_n_in, .delay_code_in, .sync_gate_in(sync_gate),
    .capture_set_reset_in, .capture_polarity_in(capture_clock_polarity_out),
    .write_rise_data_in, .write_fall_data_in, .strobe_rise_data_in(misc[4]),
    .strobe_fall_data_in(misc[3]), .dq_tristate_rise_in(misc[2]),
    .dq_tristate_fall_in(misc[1]), .strobe_tristate_in(misc[0]), .output_set_reset_in,
    .delay_code_out, .delayed_strobe_out(dly_strobe), .raw_strobe_copy_out(raw_copy),
    .preamble_detect_out, .capture_clock_polarity_out, .rising_capture_out,
    .falling_capture_out, .dq_out, .dq_oe_n_out, .strobe_out, .strobe_oe_n_out,
    .mem_clock_p_out(clk_p), .mem_clock_n_out(clk_n));
  ddr_mem_model #(.W(8)) u_mem (.strobe_out(mem_strobe), .dq_out(mem_dq));

  always #10 clk_in = ~clk_in;

  // Xorshift source of stimulus values
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One read: pulse with the command, dropped inside the preamble
  task automatic read_burst(input int n);
    logic [15:0] beats[$];
    logic [31:0] r;
    logic        lvl;
    logic        raw_ok;
    int          d;
    for (int k = 0; k < 4; k++) begin
      r = nxt();
      beats.push_back({r[15:9], ~k[0], r[7:0]}); // Each beat differs from the last
    end
    exp_q = {exp_q, beats};
    d = n[0] ? 17 : 5; // First strobe rise alternates clock low and high phase
    @(negedge clk_in);
    read_pulse_in = 1'h1;
    @(negedge clk_in);
    fork
      begin
        #(d);
        u_mem.burst(beats);
      end
      begin
        @(negedge clk_in);
        read_pulse_in = 1'h0;
      end
      begin
        @(posedge mem_strobe);
        lvl = clk_in;
      end
      begin
        for (int j = 0; j < 12 && !raw_copy; j++) begin
          @(negedge clk_in);
        end
        raw_ok = raw_copy;
      end
    join
    check(16'(raw_ok), 16'h0001);
    check(16'(preamble_detect_out), 16'h0001);
    check(16'(capture_clock_polarity_out), 16'(lvl));
  endtask

  // Compare each new captured pair with the oldest expected beat
  always @(negedge clk_in) begin
    if (watch && cap !== prev) begin
      check(cap, (exp_q.size() > 0) ? exp_q.pop_front() : ~cap);
    end
    prev = cap;
    // Delayed strobe view trails the undelayed copy by one clock
    if (!rst_in) begin
      check(16'(dly_strobe), 16'(raw_prev));
    end
    raw_prev = raw_copy;
  end

  // Cut a hung run short
  initial begin
    repeat (20000) @(posedge clk_in);
    check(16'h0001, 16'h0000);
    report_and_stop();
  end

  initial begin
    logic [31:0] r;
    logic [15:0] q[$];
    repeat (5) @(negedge clk_in);
    rst_in = 1'h0;
    repeat (2) @(negedge clk_in);
    // Code loads while update is low, then holds
    r = nxt();
    delay_code_in = r[8:0];
    delay_update_n_in = 1'h0;
    repeat (3) @(negedge clk_in);
    check(16'(delay_code_out), 16'(r[8:0]));
    delay_update_n_in = 1'h1;
    delay_code_in = ~r[8:0];
    repeat (3) @(negedge clk_in);
    check(16'(delay_code_out), 16'(r[8:0]));
    $display("test delay_code done");
    // Random write halves and tristate controls
    output_set_reset_in = 1'h0;
    for (int i = 0; i < 24; i++) begin
      @(negedge clk_in);
      r = nxt();
      {write_rise_data_in, write_fall_data_in} = r[15:0];
      misc = r[20:16];
      @(posedge clk_in);
      #5;
      check(16'(dq_out), 16'(r[15:8]));
      check(16'(strobe_out), 16'(r[20]));
      check(16'(dq_oe_n_out), {8'h00, {8{r[18]}}});
      check(16'(strobe_oe_n_out), 16'(r[16]));
      check(16'({clk_p, clk_n}), 16'({CLK_PAIR_P_RISE, CLK_PAIR_P_FALL}));
      #10;
      check(16'(dq_out), 16'(r[7:0]));
      check(16'(strobe_out), 16'(r[19]));
      check(16'(dq_oe_n_out), {8'h00, {8{r[17]}}});
      check(16'({clk_p, clk_n}), 16'({CLK_PAIR_P_FALL, CLK_PAIR_P_RISE}));
    end
    $display("test write_halves done");
    // Set/reset releases data pins but drives the strobe tristate low
    @(negedge clk_in);
    output_set_reset_in = 1'h1;
    misc = 5'h01;
    @(posedge clk_in);
    #5;
    check(16'(dq_oe_n_out), 16'h00FF);
    check(16'(strobe_oe_n_out), 16'h0000);
    @(negedge clk_in);
    output_set_reset_in = 1'h0;
    $display("test tristate_set done");
    watch = 1'h1;
    for (int i = 0; i < 4; i++) begin
      read_burst(i);
    end
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) begin
      @(negedge clk_in);
    end
    check(16'(exp_q.size()), 16'h0000);
    if (exp_q.size() > 0) begin
      report_and_stop();
    end
    $display("test read_bursts done");
    // Clear of the synchronisation registers, then the gate holds them
    watch = 1'h0;
    sync_gate = 1'h0;
    capture_set_reset_in = 1'h1;
    repeat (3) @(negedge clk_in);
    check(cap, 16'h0000);
    capture_set_reset_in = 1'h0;
    r = nxt();
    q.push_back(r[15:0] | 16'h0101);
    u_mem.burst(q);
    repeat (3) @(negedge clk_in);
    check(cap, 16'h0000);
    sync_gate = 1'h1;
    repeat (3) @(negedge clk_in);
    check(cap, q[0]);
    $display("test capture_clear done");
    report_and_stop();
  end
endmodule
